// File: csfr_bank.sv
// core special-function register bank with flag register and data memory
`timescale 1ns/100ps
module csfr_bank
	import csfr_pkg::*;
#(
	parameter int unsigned GPR_DEPTH = CSFR_GPR_DEPTH
) (
	input  wire logic       SYS_CLK_I,
	input  wire logic       RESET_I,
	input  wire logic       CLK_EN_I,
	input  wire logic [6:0] FILE_ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	input  wire csfr_alu_t  ALU_I,
	input  wire csfr_evt_t  EVT_I,
	input  wire logic       EXT_RST_I,
	input  wire logic       WDT_RST_I,
	output logic      [7:0] RDATA_O,
	output logic      [7:0] STATUS_O
);

	logic       ext_rst_m_q;
	logic       ext_rst_s_q;
	logic       other_rst;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] sfr_q [0:CSFR_NREG-1];
	logic [7:0] gpr_mem [0:GPR_DEPTH-1];
	logic [7:0] dir_addr;
	logic [7:0] eff_addr;
	logic [7:0] norm_addr;
	logic       gpr_hit;
	logic [6:0] gpr_idx;
	logic [7:0] rd_val;
	logic [7:0] rdata_q;
	logic       st_wr;
	logic       flag_z;
	logic       flag_dc;
	logic       flag_c;
	logic       upd_z;
	logic       upd_cdc;
	logic [8:0] sum9;
	logic [4:0] sum5;

	// external reset pin is asynchronous to the core clock
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ext_rst_m_q <= 1'b0;
			ext_rst_s_q <= 1'b0;
		end else if (CLK_EN_I) begin
			ext_rst_m_q <= EXT_RST_I;
			ext_rst_s_q <= ext_rst_m_q;
		end
	end

	assign other_rst = ext_rst_s_q | WDT_RST_I;

	// address formation: bank bit plus file address, or the pointer
	always_comb begin
		dir_addr = {status_q[CSFR_ST_BANK_LO], FILE_ADDR_I};
		if (FILE_ADDR_I == CSFR_OFS_IND_PORT[6:0]) begin
			eff_addr = sfr_q[CSFR_IDX_PTR];
		end else begin
			eff_addr = dir_addr;
		end
	end

	// core registers appear in both banks; upper bank tail aliases lower memory
	always_comb begin
		norm_addr = eff_addr;
		case (eff_addr[6:0])
			CSFR_OFS_IND_PORT[6:0], CSFR_OFS_PC_LOW[6:0], CSFR_OFS_STATUS[6:0],
			CSFR_OFS_IND_PTR[6:0], CSFR_OFS_PC_LATCH[6:0], CSFR_OFS_INT_CTRL[6:0]: begin
				norm_addr = eff_addr | CSFR_BANK1_BIT;
			end
			default: begin
				if (eff_addr >= CSFR_ALIAS_LO) begin
					norm_addr = eff_addr & ~CSFR_BANK1_BIT;
				end
			end
		endcase
	end

	// general purpose memory decode
	always_comb begin
		gpr_hit = 1'b0;
		gpr_idx = 7'h00;
		if (norm_addr >= CSFR_GPR0_LO && norm_addr <= CSFR_GPR0_HI) begin
			gpr_hit = 1'b1;
			gpr_idx = 7'(norm_addr - CSFR_GPR0_LO);
		end else if (norm_addr >= CSFR_GPR1_LO && norm_addr <= CSFR_GPR1_HI) begin
			gpr_hit = 1'b1;
			gpr_idx = 7'(norm_addr - CSFR_GPR1_LO + CSFR_GPR1_BASE);
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (CLK_EN_I && WR_I && gpr_hit) begin
			gpr_mem[gpr_idx] <= WDATA_I;
		end
	end

	// flag computation from the instruction datapath
	always_comb begin
		sum9    = 9'h000;
		sum5    = 5'h00;
		flag_z  = 1'b0;
		flag_dc = 1'b0;
		flag_c  = 1'b0;
		upd_z   = 1'b0;
		upd_cdc = 1'b0;
		case (ALU_I.op)
			CSFR_ALU_ADD: begin
				sum9    = {1'b0, ALU_I.a} + {1'b0, ALU_I.b};
				sum5    = {1'b0, ALU_I.a[3:0]} + {1'b0, ALU_I.b[3:0]};
				flag_z  = (sum9[7:0] == 8'h00);
				flag_dc = sum5[CSFR_NIB];
				flag_c  = sum9[8];
				upd_z   = 1'b1;
				upd_cdc = 1'b1;
			end
			CSFR_ALU_SUB: begin
				// b minus a by two's complement add: carry high means no borrow
				sum9    = {1'b0, ALU_I.b} + {1'b0, ~ALU_I.a} + 9'h001;
				sum5    = {1'b0, ALU_I.b[3:0]} + {1'b0, ~ALU_I.a[3:0]} + 5'h01;
				flag_z  = (sum9[7:0] == 8'h00);
				flag_dc = sum5[CSFR_NIB];
				flag_c  = sum9[8];
				upd_z   = 1'b1;
				upd_cdc = 1'b1;
			end
			CSFR_ALU_LOGIC: begin
				flag_z = (ALU_I.res == 8'h00);
				upd_z  = 1'b1;
			end
			CSFR_ALU_CLR: begin
				flag_z = 1'b1;
				upd_z  = 1'b1;
			end
			default: begin
				upd_z = 1'b0;
			end
		endcase
	end

	assign st_wr = WR_I && (norm_addr == CSFR_OFS_STATUS);

	// flag register next value
	always_comb begin
		status_d = status_q;
		if (st_wr) begin
			status_d[CSFR_ST_IND_BANK] = WDATA_I[CSFR_ST_IND_BANK];
			status_d[CSFR_ST_BANK_HI]  = WDATA_I[CSFR_ST_BANK_HI];
			status_d[CSFR_ST_BANK_LO]  = WDATA_I[CSFR_ST_BANK_LO];
			// any flag-affecting op blocks data on all three arithmetic flags
			if (!upd_z) begin
				status_d[CSFR_ST_Z]   = WDATA_I[CSFR_ST_Z];
				status_d[CSFR_ST_DGT] = WDATA_I[CSFR_ST_DGT];
				status_d[CSFR_ST_C]   = WDATA_I[CSFR_ST_C];
			end
			// timeout and powerdown are left to hardware events
		end
		if (upd_z) begin
			status_d[CSFR_ST_Z] = flag_z;
		end
		if (upd_cdc) begin
			status_d[CSFR_ST_DGT] = flag_dc;
			status_d[CSFR_ST_C]   = flag_c;
		end
		if (EVT_I.clr_wdt) begin
			status_d[CSFR_ST_WDTO] = 1'b1;
			status_d[CSFR_ST_PWDN] = 1'b1;
		end
		if (EVT_I.sleep) begin
			status_d[CSFR_ST_WDTO] = 1'b1;
			status_d[CSFR_ST_PWDN] = 1'b0;
		end
		if (EVT_I.wdt_timeout) begin
			status_d[CSFR_ST_WDTO] = 1'b0;
		end
		if (other_rst) begin
			status_d = (status_d & ~CSFR_STATUS_KEEP) | (status_q & CSFR_STATUS_KEEP);
			status_d[CSFR_ST_IND_BANK] = 1'b0;
			status_d[CSFR_ST_BANK_HI]  = 1'b0;
			status_d[CSFR_ST_BANK_LO]  = 1'b0;
			if (WDT_RST_I) begin
				status_d[CSFR_ST_WDTO] = 1'b0;
			end
		end
	end

	// ALU, reset-cause and bank bits share one register
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			status_q <= CSFR_STATUS_POR;
		end else if (CLK_EN_I) begin
			status_q <= status_d;
		end
	end

	// plain storage registers, one per table entry
	generate
		for (genvar gi = 0; gi < CSFR_NREG; gi++) begin : g_sfr
			always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
				if (RESET_I) begin
					sfr_q[gi] <= CSFR_REG_POR[gi];
				end else if (CLK_EN_I) begin
					if (other_rst) begin
						sfr_q[gi] <= (sfr_q[gi] & CSFR_REG_KEEP[gi])
							| (CSFR_REG_POR[gi] & ~CSFR_REG_KEEP[gi]);
					end else if (WR_I && norm_addr == CSFR_REG_OFS[gi]) begin
						sfr_q[gi] <= WDATA_I & CSFR_REG_MASK[gi];
					end
				end
			end
		end
	endgenerate

	// read mux; anything unmatched reads zero
	always_comb begin
		rd_val = 8'h00;
		if (gpr_hit) begin
			rd_val = gpr_mem[gpr_idx];
		end else if (norm_addr == CSFR_OFS_STATUS) begin
			rd_val = status_q;
		end else begin
			for (int i = 0; i < CSFR_NREG; i++) begin
				if (norm_addr == CSFR_REG_OFS[i]) begin
					rd_val = sfr_q[i] & CSFR_REG_MASK[i];
				end
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			rdata_q <= 8'h00;
		end else if (CLK_EN_I) begin
			rdata_q <= RD_I ? rd_val : 8'h00;
		end
	end

	assign RDATA_O  = rdata_q;
	assign STATUS_O = status_q;

endmodule : csfr_bank

// File: csfr_pkg.sv
// constants, types and register map of the core special-function register bank
//
// Overview of operation
// - flag register writable by any instruction
// - ALU-affected flag bits take ALU result, not data
// - timeout and powerdown flags ignore software writes
// - clear-file on flags: upper three zero, zero set
// - subtraction drives carries as inverted borrows
// - unimplemented locations and bits read zero
// - power-on and other resets load separate values
// - one register holds ALU, reset, bank bits
package csfr_pkg;

	// flag register fields
	localparam int unsigned CSFR_ST_C        = 0;
	localparam int unsigned CSFR_ST_DGT      = 1;
	localparam int unsigned CSFR_ST_Z        = 2;
	localparam int unsigned CSFR_ST_PWDN     = 3;
	localparam int unsigned CSFR_ST_WDTO     = 4;
	localparam int unsigned CSFR_ST_BANK_LO  = 5;
	localparam int unsigned CSFR_ST_BANK_HI  = 6;
	localparam int unsigned CSFR_ST_IND_BANK = 7;
	localparam int unsigned CSFR_NIB         = 4;

	// register offsets, bank-resolved
	localparam logic [7:0] CSFR_OFS_PER_FLAGS = 8'h0C;
	localparam logic [7:0] CSFR_OFS_CMP_CTRL  = 8'h1F;
	localparam logic [7:0] CSFR_OFS_IND_PORT  = 8'h80;
	localparam logic [7:0] CSFR_OFS_OPTION    = 8'h81;
	localparam logic [7:0] CSFR_OFS_PC_LOW    = 8'h82;
	localparam logic [7:0] CSFR_OFS_STATUS    = 8'h83;
	localparam logic [7:0] CSFR_OFS_IND_PTR   = 8'h84;
	localparam logic [7:0] CSFR_OFS_DIR_A     = 8'h85;
	localparam logic [7:0] CSFR_OFS_DIR_B     = 8'h86;
	localparam logic [7:0] CSFR_OFS_PC_LATCH  = 8'h8A;
	localparam logic [7:0] CSFR_OFS_INT_CTRL  = 8'h8B;
	localparam logic [7:0] CSFR_OFS_PER_EN    = 8'h8C;
	localparam logic [7:0] CSFR_OFS_RST_CAUSE = 8'h8E;
	localparam logic [7:0] CSFR_OFS_EE_PINS   = 8'h90;
	localparam logic [7:0] CSFR_OFS_VREF_CTRL = 8'h9F;
	localparam logic [7:0] CSFR_BANK1_BIT     = 8'h80;

	// flag register reset values
	localparam logic [7:0] CSFR_STATUS_POR  = 8'h18;
	localparam logic [7:0] CSFR_STATUS_KEEP = 8'h07;

	// general purpose data memory windows
	localparam logic [7:0] CSFR_GPR0_LO   = 8'h20;
	localparam logic [7:0] CSFR_GPR0_HI   = 8'h7F;
	localparam logic [7:0] CSFR_GPR1_LO   = 8'hA0;
	localparam logic [7:0] CSFR_GPR1_HI   = 8'hBF;
	localparam logic [7:0] CSFR_ALIAS_LO  = 8'hF0;
	localparam logic [7:0] CSFR_GPR1_BASE = 8'h60;
	localparam int unsigned CSFR_GPR_DEPTH = 128;

	// plain storage registers: offset, writable mask, power-on value, kept on other reset
	localparam int unsigned CSFR_NREG    = 13;
	localparam int unsigned CSFR_IDX_PTR = 2;
	localparam logic [7:0] CSFR_REG_OFS [0:CSFR_NREG-1] = '{
		CSFR_OFS_OPTION, CSFR_OFS_PC_LOW, CSFR_OFS_IND_PTR, CSFR_OFS_DIR_A, CSFR_OFS_DIR_B,
		CSFR_OFS_PC_LATCH, CSFR_OFS_INT_CTRL, CSFR_OFS_PER_EN, CSFR_OFS_RST_CAUSE,
		CSFR_OFS_PER_FLAGS, CSFR_OFS_CMP_CTRL, CSFR_OFS_VREF_CTRL, CSFR_OFS_EE_PINS};
	localparam logic [7:0] CSFR_REG_MASK [0:CSFR_NREG-1] = '{
		8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'h40, 8'h03, 8'h40,
		8'h0F, 8'hEF, 8'h07};
	localparam logic [7:0] CSFR_REG_POR [0:CSFR_NREG-1] = '{
		8'hFF, 8'h00, 8'h00, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam logic [7:0] CSFR_REG_KEEP [0:CSFR_NREG-1] = '{
		8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00,
		8'h00, 8'h00, 8'h07};

	typedef enum logic [2:0] {
		CSFR_ALU_NONE  = 3'h0,
		CSFR_ALU_ADD   = 3'h1,
		CSFR_ALU_SUB   = 3'h2,
		CSFR_ALU_LOGIC = 3'h3,
		CSFR_ALU_CLR   = 3'h4
	} csfr_alu_op_t;

	// flag request from the instruction datapath
	typedef struct packed {
		csfr_alu_op_t op;
		logic [7:0]   a;
		logic [7:0]   b;
		logic [7:0]   res;
	} csfr_alu_t;

	// hardware reset-cause events
	typedef struct packed {
		logic clr_wdt;
		logic sleep;
		logic wdt_timeout;
	} csfr_evt_t;

endpackage : csfr_pkg

// File: csfr_bank_assertions.sv
// bound checker for the register bank ports
`timescale 1ns/100ps
module csfr_bank_checker
	import csfr_pkg::*;
(
	input wire logic       SYS_CLK_I,
	input wire logic       RESET_I,
	input wire logic       CLK_EN_I,
	input wire logic [6:0] FILE_ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire csfr_alu_t  ALU_I,
	input wire csfr_evt_t  EVT_I,
	input wire logic       EXT_RST_I,
	input wire logic       WDT_RST_I,
	input wire logic [7:0] RDATA_O,
	input wire logic [7:0] STATUS_O
);
	logic [2:0] ext_q;
	logic       quiet;
	logic       st_wr;

	// external reset still crossing the synchroniser
	always_ff @(posedge SYS_CLK_I or posedge RESET_I)
		if (RESET_I)
			ext_q <= 3'h0;
		else
			ext_q <= {ext_q[1:0], EXT_RST_I};

	assign quiet = CLK_EN_I && !WDT_RST_I && !EXT_RST_I && ext_q == 3'h0;
	assign st_wr = quiet && WR_I && FILE_ADDR_I == 7'h03;

	default clocking @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	por_value_a: assert property ($fell(RESET_I) |-> STATUS_O == CSFR_STATUS_POR)
		else $error("bad power-on flags");
	wdt_clear_a: assert property (CLK_EN_I && WDT_RST_I |=> STATUS_O[7:4] == 4'h0)
		else $error("bad watchdog flags");
	read_zero_a: assert property (CLK_EN_I && (!RD_I || FILE_ADDR_I == 7'h07)
		|=> RDATA_O == 8'h00) else $error("nonzero read data");
	flag_write_a: assert property (st_wr && ALU_I.op == CSFR_ALU_NONE |=>
		{STATUS_O[7:5], STATUS_O[2:0]} == $past({WDATA_I[7:5], WDATA_I[2:0]}))
		else $error("flag write lost");
	tp_locked_a: assert property (st_wr && EVT_I == 3'h0 |=>
		STATUS_O[4:3] == $past(STATUS_O[4:3])) else $error("cause flags written");
	clear_file_a: assert property (st_wr && WDATA_I == 8'h00 && ALU_I.op == CSFR_ALU_CLR |=>
		STATUS_O[7:5] == 3'h0 && STATUS_O[2] && STATUS_O[1:0] == $past(STATUS_O[1:0]))
		else $error("bad clear result");
	sub_borrow_a: assert property (quiet && ALU_I.op == CSFR_ALU_SUB |=>
		STATUS_O[1] == ($past(ALU_I.b[3:0]) >= $past(ALU_I.a[3:0])) &&
		STATUS_O[0] == ($past(ALU_I.b) >= $past(ALU_I.a))) else $error("bad borrow flags");
	add_carry_a: assert property (quiet && ALU_I.op == CSFR_ALU_ADD |=>
		STATUS_O[0] == ($past(ALU_I.a) + 9'h000 + $past(ALU_I.b) > 9'h0FF))
		else $error("bad carry flag");
endmodule : csfr_bank_checker

bind csfr_bank csfr_bank_checker chk_u (
	.SYS_CLK_I   (SYS_CLK_I),
	.RESET_I     (RESET_I),
	.CLK_EN_I    (CLK_EN_I),
	.FILE_ADDR_I (FILE_ADDR_I),
	.WDATA_I     (WDATA_I),
	.WR_I        (WR_I),
	.RD_I        (RD_I),
	.ALU_I       (ALU_I),
	.EVT_I       (EVT_I),
	.EXT_RST_I   (EXT_RST_I),
	.WDT_RST_I   (WDT_RST_I),
	.RDATA_O     (RDATA_O),
	.STATUS_O    (STATUS_O)
);

// File: csfr_core_model.sv
// core datapath model driving the register port
`timescale 1ns/100ps
module csfr_core_model
	import csfr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output logic      [6:0] addr_o = 7'h00,
	output logic      [7:0] wdata_o = 8'h00,
	output logic            wr_o = 1'b0,
	output logic            rd_o = 1'b0,
	output csfr_alu_t       alu_o = '0
);
	task automatic file_op(input logic w, input logic [6:0] a, input logic [7:0] d,
		input csfr_alu_t u);
		@(posedge clk_i);
		wr_o <= w;
		addr_o <= a;
		wdata_o <= (a == 7'h03) ? (d & 8'h3F) : d;
		alu_o <= u;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
		alu_o <= '0;
		#1;
	endtask : file_op

	task automatic file_rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask : file_rd
endmodule : csfr_core_model

// File: test_core_sfr_bank_status_flags.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
module test_core_sfr_bank_status_flags
	import csfr_pkg::*;
();
	logic       clk;
	logic       rst;
	logic       ext_rst;
	logic       wdt_rst;
	csfr_evt_t  evt;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	csfr_alu_t  alu;
	logic [7:0] rdata;
	logic [7:0] status;
	logic [7:0] got;
	int         miscompares = 0;
	int         total_checks = 0;
	int         cycles = 0;

	csfr_bank dut (.SYS_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .FILE_ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .ALU_I(alu), .EVT_I(evt), .EXT_RST_I(ext_rst),
		.WDT_RST_I(wdt_rst), .RDATA_O(rdata), .STATUS_O(status));
	csfr_core_model core (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .alu_o(alu));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		core.file_rd(a, got);
		chk(got, exp);
	endtask : rchk

	// one-cycle pulse on {ext, wdt, events}
	task automatic hw(input logic [4:0] v);
		@(posedge clk);
		{ext_rst, wdt_rst, evt} <= v;
		@(posedge clk);
		{ext_rst, wdt_rst, evt} <= 5'h00;
		#1;
	endtask : hw

	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		rst = 1'b1;
		{ext_rst, wdt_rst, evt} = 5'h00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1 chk(status, CSFR_STATUS_POR);
		core.file_op(1'b1, 7'h03, 8'h27, '0);
		chk(status, 8'h3F);
		rchk(7'h01, 8'hFF);
		rchk(7'h05, 8'h1F);
		rchk(7'h06, 8'hFF);
		rchk(7'h0D, 8'h00);
		core.file_op(1'b1, 7'h03, 8'h00, '{CSFR_ALU_CLR, 8'h00, 8'h00, 8'h00});
		chk(status, 8'h1F);
		$display("test flag writes done");
		core.file_op(1'b1, 7'h04, 8'h20, '0);
		core.file_op(1'b1, 7'h00, 8'h5A, '0);
		rchk(7'h20, 8'h5A);
		rchk(7'h00, 8'h5A);
		$display("test indirect done");
		core.file_op(1'b0, 7'h00, 8'h00, '{CSFR_ALU_SUB, 8'h01, 8'h10, 8'h0F});
		chk(status, 8'h19);
		core.file_op(1'b0, 7'h00, 8'h00, '{CSFR_ALU_SUB, 8'h10, 8'h01, 8'hF1});
		chk(status, 8'h1A);
		core.file_op(1'b1, 7'h03, 8'h07, '{CSFR_ALU_ADD, 8'hF0, 8'h10, 8'h00});
		chk(status, 8'h1D);
		core.file_op(1'b1, 7'h03, 8'h04, '{CSFR_ALU_LOGIC, 8'h00, 8'h00, 8'h55});
		chk(status, 8'h19);
		core.file_op(1'b0, 7'h00, 8'h00, '{CSFR_ALU_LOGIC, 8'h00, 8'h00, 8'h00});
		chk(status, 8'h1D);
		$display("test alu flags done");
		hw(5'h08);
		chk(status, 8'h0D);
		hw(5'h02);
		chk(status, 8'h15);
		hw(5'h04);
		chk(status, 8'h1D);
		core.file_op(1'b1, 7'h03, 8'h25, '0);
		hw(5'h10);
		repeat (3) @(posedge clk);
		#1 chk(status, 8'h1D);
		rchk(7'h04, 8'h20);
		rchk(7'h07, 8'h00);
		$display("test resets done");
		finish_test();
	end
endmodule : test_core_sfr_bank_status_flags
